// >>> core_side_model.sv
// Stand-in for the supply monitor, reset pin, debugger and core fetch.
`timescale 1ns/1ps
module core_side_model (
  input  wire logic        clock,
  input  wire logic        droopReq,
  input  wire logic        pinReq,
  input  wire logic        dbgReq,
  input  wire logic        coreResetN,
  input  wire logic [31:0] bootAddr,
  output logic             lfClock,
  output logic             supplyDroop,
  output logic             extResetN,
  output logic             debugAttached,
  output logic      [31:0] fetchAddr
);
  logic [1:0] div;

  // The low-speed clock is scaled to one period per eight system clocks.
  initial
  begin
    div       = 2'h0;
    lfClock   = 1'b0;
    fetchAddr = 32'hffffffff;
  end

  always @(posedge clock)
  begin
    div <= div + 2'h1;
    if (div == 2'h3)
      lfClock <= ~lfClock;
  end

  assign supplyDroop   = droopReq;
  assign extResetN     = ~pinReq;
  assign debugAttached = dbgReq;

  // The core takes its first fetch address as it leaves reset.
  always @(posedge coreResetN)
    fetchAddr = bootAddr;
endmodule : core_side_model

// >>> pin_sync.sv
// Two-flop synchroniser for a group of independent level inputs.
`timescale 1ns/1ps
module pin_sync #(
  parameter int W = 1
) (
  input  wire logic         clock,
  input  wire logic         rstN,
  input  wire logic         clockEn,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_r;

  always_ff @(posedge clock or negedge rstN)
  begin
    if (!rstN)
    begin
      meta_r <= '0;
      q      <= '0;
    end
    else if (clockEn)
    begin
      meta_r <= d;
      q      <= meta_r;
    end
  end
endmodule : pin_sync

// >>> reset_and_watchdog_control.sv
// Reset source gathering, reset cause record and lockable supervision timer.
//
// Summary of operation
// - Five reset causes: power-on, supply droop, reset pin, software, timer overflow.
// - Power-on and supply droop fully reset everything, debug logic included.
// - Core supply dropping low after power-up raises a supply droop reset.
// - After power-on or droop reset the core fetches from address zero.
// - Reset is held for as long as the reset pin stays low.
// - The reset pin resets everything except the debug logic.
// - Software reset is partial; retained registers keep their contents.
// - The supervision timer leaves reset disabled until software enables it.
// - While locked, the timer accepts only a clear or a lock write; control and warning writes are ignored.
// - The timer counter is 18 bits and advances on the 32.768 kHz clock.
// - Timer overflow resets the system and records the timer as cause.
// - The timer counter does not advance while a debugger is attached.
// - The timer warning drives the core's non-maskable interrupt.
`timescale 1ns/1ps
module reset_and_watchdog_control (
  input  wire logic        clock,
  input  wire logic        resetn,
  input  wire logic        clockEn,
  input  wire logic        lfClock,
  input  wire logic        supplyDroop,
  input  wire logic        extResetN,
  input  wire logic        debugAttached,
  input  wire logic [5:0]  address,
  input  wire logic        read,
  input  wire logic        write,
  input  wire logic [31:0] writedata,
  output logic      [31:0] readdata,
  output logic             waitrequest,
  output logic             irq,
  output logic             nmi,
  output logic             debugResetN,
  output logic             retainResetN,
  output logic             coreResetN,
  output logic      [31:0] bootAddr
);
  logic        rstN;
  logic [3:0]  pinSync;
  logic        lfS;
  logic        droopS;
  logic        extS;
  logic        dbgS;
  logic        lfPrev_r;
  logic        droopPrev_r;
  logic        extPrev_r;
  logic        debugSrcN;
  logic        retainSrcN;
  logic        coreSrcN;
  logic        ack_r;
  logic        wrAcc;
  logic        wrCtrl;
  logic        wrWarn;
  logic        clrAcc;
  logic        wrLock;
  logic        swReq;
  logic        wrStatus;
  logic        wrMask;
  logic        timerEn_r;
  logic        locked_r;
  logic [17:0] warn_r;
  logic [17:0] count_r;
  logic        advance;
  logic        timerOvf;
  logic        warnEv;
  logic        extEv;
  logic        droopEv;
  logic        swHold_r;
  logic        timerHold_r;
  logic [4:0]  holdCnt_r;
  logic [4:0]  status_r;
  logic [4:0]  mask_r;
  logic [4:0]  cause_r;
  logic [4:0]  events;
  logic [31:0] readNxt;

  // Local reset taken from the power-on input through two flops.
  reset_sync porSync (
    .clock   (clock),
    .clockEn (1'b1),
    .srcN    (resetn),
    .syncN   (rstN)
  );

  pin_sync #(.W(4)) inSync (
    .clock   (clock),
    .rstN    (rstN),
    .clockEn (clockEn),
    .d       ({debugAttached, ~extResetN, supplyDroop, lfClock}),
    .q       (pinSync)
  );

  assign lfS    = pinSync[0];
  assign droopS = pinSync[1];
  assign extS   = ~pinSync[2]; // Inverted through the flops so that reset reads as idle.
  assign dbgS   = pinSync[3];

  // Each reset output nests inside the wider one above it.
  assign debugSrcN  = rstN & ~supplyDroop;
  // The pin joins below the debug domain, so debug logic is spared.
  assign retainSrcN = debugSrcN & extResetN & ~timerHold_r;
  // Software reset reaches only the non-retained domain.
  assign coreSrcN   = retainSrcN & ~swHold_r;

  reset_sync debugSync (
    .clock   (clock),
    .clockEn (clockEn),
    .srcN    (debugSrcN),
    .syncN   (debugResetN)
  );

  reset_sync retainSync (
    .clock   (clock),
    .clockEn (clockEn),
    .srcN    (retainSrcN),
    .syncN   (retainResetN)
  );

  reset_sync coreSync (
    .clock   (clock),
    .clockEn (clockEn),
    .srcN    (coreSrcN),
    .syncN   (coreResetN)
  );

  // The fetch address is reloaded while the core is held in reset.
  always_ff @(posedge clock or negedge rstN)
  begin
    if (!rstN)
      bootAddr <= rst_wdog_pkg::BOOT_ADDR;
    else if (clockEn && !coreResetN)
      bootAddr <= rst_wdog_pkg::BOOT_ADDR;
  end

  always_ff @(posedge clock or negedge rstN)
  begin
    if (!rstN)
    begin
      lfPrev_r    <= 1'b0;
      droopPrev_r <= 1'b0;
      extPrev_r   <= 1'b1;
    end
    else if (clockEn)
    begin
      lfPrev_r    <= lfS;
      droopPrev_r <= droopS;
      extPrev_r   <= extS;
    end
  end

  assign droopEv = droopS & ~droopPrev_r;
  assign extEv   = ~extS & extPrev_r;

  // One wait state: the request is answered on the second edge.
  always_ff @(posedge clock or negedge rstN)
  begin
    if (!rstN)
      ack_r <= 1'b0;
    else if (clockEn)
      ack_r <= (read | write) & ~ack_r;
  end

  assign waitrequest = (read | write) & ~ack_r;
  assign wrAcc       = write & ack_r;
  assign wrCtrl      = wrAcc & (address == rst_wdog_pkg::OFS_CTRL);
  assign wrWarn      = wrAcc & (address == rst_wdog_pkg::OFS_WARN);
  assign clrAcc      = wrAcc & (address == rst_wdog_pkg::OFS_CLEAR);
  assign wrLock      = wrAcc & (address == rst_wdog_pkg::OFS_LOCK);
  assign wrStatus    = wrAcc & (address == rst_wdog_pkg::OFS_STATUS);
  assign wrMask      = wrAcc & (address == rst_wdog_pkg::OFS_MASK);
  assign swReq       = wrAcc & (address == rst_wdog_pkg::OFS_SWRST)
                       & writedata[rst_wdog_pkg::SWRST_BIT];

  always_comb
  begin
    readNxt = 32'h00000000;
    case (address)
      rst_wdog_pkg::OFS_CTRL:   readNxt[rst_wdog_pkg::CTRL_EN_BIT] = timerEn_r;
      rst_wdog_pkg::OFS_WARN:   readNxt[17:0] = warn_r;
      rst_wdog_pkg::OFS_COUNT:  readNxt[17:0] = count_r;
      rst_wdog_pkg::OFS_LOCK:   readNxt[rst_wdog_pkg::LOCK_BIT] = locked_r;
      rst_wdog_pkg::OFS_CAUSE:  readNxt[4:0] = cause_r;
      rst_wdog_pkg::OFS_STATUS: readNxt[4:0] = status_r;
      rst_wdog_pkg::OFS_MASK:   readNxt[4:0] = mask_r;
      default:                  readNxt = 32'h00000000;
    endcase
  end

  always_ff @(posedge clock or negedge rstN)
  begin
    if (!rstN)
      readdata <= 32'h00000000;
    else if (clockEn && read && !ack_r)
      readdata <= readNxt;
  end

  // Timer control is cleared by every reset of the retained domain.
  always_ff @(posedge clock or negedge rstN)
  begin
    if (!rstN)
    begin
      timerEn_r <= 1'b0;
      warn_r    <= rst_wdog_pkg::WARN_RESET;
      locked_r  <= 1'b0;
    end
    else if (clockEn)
    begin
      if (!retainResetN)
      begin
        timerEn_r <= 1'b0;
        warn_r    <= rst_wdog_pkg::WARN_RESET;
        locked_r  <= 1'b0;
      end
      else
      begin
        if (wrCtrl && !locked_r)
          timerEn_r <= writedata[rst_wdog_pkg::CTRL_EN_BIT];
        if (wrWarn && !locked_r)
          warn_r <= writedata[17:0];
        if (wrLock)
          locked_r <= (writedata[15:0] != rst_wdog_pkg::UNLOCK_KEY);
      end
    end
  end

  // Counting steps once per rising low-speed edge, paused by a debugger.
  assign advance  = timerEn_r & retainResetN & lfS & ~lfPrev_r & ~dbgS & ~clrAcc;
  assign timerOvf = advance & (count_r == rst_wdog_pkg::TIMER_MAX);
  assign warnEv   = advance & (count_r == warn_r);

  always_ff @(posedge clock or negedge rstN)
  begin
    if (!rstN)
      count_r <= '0;
    else if (clockEn)
    begin
      if (!retainResetN || !timerEn_r)
        count_r <= '0;
      else if (clrAcc)
        count_r <= '0;
      else if (advance)
        count_r <= count_r + 18'h00001;
    end
  end

  // Software and overflow requests are stretched into reset pulses.
  always_ff @(posedge clock or negedge rstN)
  begin
    if (!rstN)
    begin
      swHold_r    <= 1'b0;
      timerHold_r <= 1'b0;
      holdCnt_r   <= 5'h00;
    end
    else if (clockEn)
    begin
      if (timerOvf)
      begin
        timerHold_r <= 1'b1;
        holdCnt_r   <= rst_wdog_pkg::HOLD_CYCLES;
      end
      else if (swReq && !timerHold_r)
      begin
        swHold_r  <= 1'b1;
        holdCnt_r <= rst_wdog_pkg::HOLD_CYCLES;
      end
      else if (holdCnt_r != 5'h00)
        holdCnt_r <= holdCnt_r - 5'h01;
      else
      begin
        swHold_r    <= 1'b0;
        timerHold_r <= 1'b0;
      end
    end
  end

  // The cause record names the most severe source of the latest reset.
  always_ff @(posedge clock or negedge rstN)
  begin
    if (!rstN)
      cause_r <= rst_wdog_pkg::CAUSE_RESET;
    else if (clockEn)
    begin
      if (droopEv)
        cause_r <= 5'h01 << rst_wdog_pkg::SRC_DROOP;
      else if (timerOvf)
        cause_r <= 5'h01 << rst_wdog_pkg::SRC_TIMER;
      else if (extEv)
        cause_r <= 5'h01 << rst_wdog_pkg::SRC_EXT;
      else if (swReq)
        cause_r <= 5'h01 << rst_wdog_pkg::SRC_SW;
    end
  end

  always_comb
  begin
    events                          = 5'h00;
    events[rst_wdog_pkg::STAT_WARN] = warnEv;
    events[rst_wdog_pkg::SRC_DROOP] = droopEv;
    events[rst_wdog_pkg::SRC_EXT]   = extEv;
    events[rst_wdog_pkg::SRC_SW]    = swReq;
    events[rst_wdog_pkg::SRC_TIMER] = timerOvf;
  end

  // Sticky status, write one to clear; a new event wins over the clear.
  always_ff @(posedge clock or negedge rstN)
  begin
    if (!rstN)
      status_r <= rst_wdog_pkg::STATUS_RESET;
    else if (clockEn)
      status_r <= (status_r & ~(wrStatus ? writedata[4:0] : 5'h00)) | events;
  end

  always_ff @(posedge clock or negedge rstN)
  begin
    if (!rstN)
      mask_r <= rst_wdog_pkg::MASK_RESET;
    else if (clockEn && wrMask)
      mask_r <= writedata[4:0];
  end

  assign irq = |(status_r & mask_r);
  // The warning bypasses the mask: it is the core's non-maskable input.
  assign nmi = status_r[rst_wdog_pkg::STAT_WARN];

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rstN);

  a_droop_full_reset: assert property (supplyDroop |-> !debugResetN && !coreResetN)
    else $error("supply droop did not reset the debug domain");
  a_pin_holds_reset: assert property (!extResetN |-> !retainResetN && !coreResetN)
    else $error("reset pin low but system out of reset");
  a_pin_spares_debug: assert property (
    (!extS && debugResetN && !supplyDroop) ##1 !supplyDroop |-> debugResetN)
    else $error("debug domain reset by the reset pin");
  a_sw_partial_reset: assert property (swReq && !timerOvf && retainResetN && extResetN
    && !supplyDroop |=> !coreResetN && retainResetN)
    else $error("software reset not partial");
  a_timer_off_idle: assert property (!timerEn_r |=> count_r == 18'h00000)
    else $error("disabled timer counted");
  a_lock_blocks_ctrl: assert property (locked_r && retainResetN && (wrCtrl || wrWarn)
    |=> $stable(timerEn_r) && $stable(warn_r))
    else $error("locked timer accepted a write");
  a_count_step: assert property (advance && count_r != rst_wdog_pkg::TIMER_MAX
    |=> count_r == $past(count_r) + 18'h00001)
    else $error("counter did not step by one");
  a_ovf_resets: assert property (timerOvf |=> !retainResetN
    && cause_r[rst_wdog_pkg::SRC_TIMER] ##1 !retainResetN)
    else $error("overflow did not reset and record the timer");
  a_debug_pause: assert property (dbgS && !clrAcc && retainResetN && timerEn_r
    |=> $stable(count_r))
    else $error("timer moved while debugger attached");
  a_warn_to_nmi: assert property (warnEv |=> nmi)
    else $error("warning did not raise the non-maskable interrupt");
  a_clear_restart: assert property (clrAcc |=> count_r == 18'h00000)
    else $error("clear did not restart the counter");
  a_boot_vector: assert property ($rose(coreResetN)
    |-> bootAddr == rst_wdog_pkg::BOOT_ADDR)
    else $error("core released with a non-zero fetch address");

  c_timer_overflow: cover property (timerOvf);
  c_sw_reset: cover property (swReq ##1 !coreResetN);
  c_locked_clear: cover property (locked_r && clrAcc);
  c_pin_reset: cover property (extEv ##[1:4] !retainResetN);
endmodule : reset_and_watchdog_control

// >>> reset_sync.sv
// Reset synchroniser: asynchronous assertion, clocked two-stage release.
`timescale 1ns/1ps
module reset_sync (
  input  wire logic clock,
  input  wire logic clockEn,
  input  wire logic srcN,
  output logic      syncN
);
  logic stage_r;

  // Assertion follows the source at once; release waits two edges.
  always_ff @(posedge clock or negedge srcN)
  begin
    if (!srcN)
    begin
      stage_r <= 1'b0;
      syncN   <= 1'b0;
    end
    else if (clockEn)
    begin
      stage_r <= 1'b1;
      syncN   <= stage_r;
    end
  end
endmodule : reset_sync

// >>> rst_wdog_pkg.sv
// Constants shared by the reset and supervision timer control logic.
package rst_wdog_pkg;
  localparam int          NUM_SOURCES   = 5;
  localparam int          TIMER_WIDTH   = 18;
  localparam int          ADDR_WIDTH    = 6;
  localparam logic [17:0] TIMER_MAX     = 18'h3ffff;
  localparam logic [17:0] WARN_RESET    = 18'h3fff0;
  localparam logic [31:0] BOOT_ADDR     = 32'h00000000;
  localparam logic [4:0]  HOLD_CYCLES   = 5'h10;
  localparam logic [15:0] UNLOCK_KEY    = 16'h5a5a;

  localparam logic [5:0]  OFS_CTRL      = 6'h00;
  localparam logic [5:0]  OFS_WARN      = 6'h04;
  localparam logic [5:0]  OFS_COUNT     = 6'h08;
  localparam logic [5:0]  OFS_CLEAR     = 6'h0c;
  localparam logic [5:0]  OFS_LOCK      = 6'h10;
  localparam logic [5:0]  OFS_SWRST     = 6'h14;
  localparam logic [5:0]  OFS_CAUSE     = 6'h18;
  localparam logic [5:0]  OFS_STATUS    = 6'h1c;
  localparam logic [5:0]  OFS_MASK      = 6'h20;

  localparam int          CTRL_EN_BIT   = 0;
  localparam int          LOCK_BIT      = 0;
  localparam int          SWRST_BIT     = 0;

  // Cause bits; status uses the same positions, with bit 0 as the warning.
  localparam int          CAUSE_POR     = 0;
  localparam int          STAT_WARN     = 0;
  localparam int          SRC_DROOP     = 1;
  localparam int          SRC_EXT       = 2;
  localparam int          SRC_SW        = 3;
  localparam int          SRC_TIMER     = 4;
  localparam logic [4:0]  CAUSE_RESET   = 5'h01;
  localparam logic [4:0]  STATUS_RESET  = 5'h00;
  localparam logic [4:0]  MASK_RESET    = 5'h00;
endpackage : rst_wdog_pkg

// >>> test_reset_and_watchdog_control.sv
// Self-checking bench for the reset and supervision timer block.
`timescale 1ns/1ps
module test_reset_and_watchdog_control;
  logic        clock;
  logic        resetn;
  logic        clockEn;
  logic        droopReq;
  logic        pinReq;
  logic        dbgReq;
  logic        lfClock;
  logic        supplyDroop;
  logic        extResetN;
  logic        debugAttached;
  logic [5:0]  address;
  logic        read;
  logic        write;
  logic [31:0] writedata;
  logic [31:0] readdata;
  logic        waitrequest;
  logic        irq;
  logic        nmi;
  logic        debugResetN;
  logic        retainResetN;
  logic        coreResetN;
  logic [31:0] bootAddr;
  logic [31:0] fetchAddr;
  logic [31:0] expQ[$];
  int          failures;
  int          comparisons;
  int          seed;

  reset_and_watchdog_control dut (
    .clock(clock), .resetn(resetn), .clockEn(clockEn), .lfClock(lfClock),
    .supplyDroop(supplyDroop), .extResetN(extResetN), .debugAttached(debugAttached),
    .address(address), .read(read), .write(write), .writedata(writedata),
    .readdata(readdata), .waitrequest(waitrequest), .irq(irq), .nmi(nmi),
    .debugResetN(debugResetN), .retainResetN(retainResetN), .coreResetN(coreResetN),
    .bootAddr(bootAddr)
  );

  core_side_model partner (
    .clock(clock), .droopReq(droopReq), .pinReq(pinReq), .dbgReq(dbgReq),
    .coreResetN(coreResetN), .bootAddr(bootAddr), .lfClock(lfClock),
    .supplyDroop(supplyDroop), .extResetN(extResetN), .debugAttached(debugAttached),
    .fetchAddr(fetchAddr)
  );

  initial
  begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  task automatic report_and_stop();
    $display("Comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : report_and_stop

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp)
    begin
      failures++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  // Holds the request until waitrequest is seen low at a rising edge.
  task automatic bus(input logic isWr, input logic [5:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clock);
    read      <= ~isWr;
    write     <= isWr;
    address   <= a;
    writedata <= d;
    do
    begin
      @(posedge clock);
      n++;
    end
    while (waitrequest !== 1'b0 && n < 50);
    if (n >= 50)
    begin
      failures++;
      $display("Error waitrequest expected 0 seen %b", waitrequest);
    end
    read  <= 1'b0;
    write <= 1'b0;
  endtask : bus

  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask : wr

  task automatic rd(input logic [5:0] a, input logic [31:0] e);
    expQ.push_back(e);
    bus(1'b0, a, 32'h0);
  endtask : rd

  task automatic wait_core(input logic lvl);
    int n;
    for (n = 0; n < 300 && coreResetN !== lvl; n++)
      @(posedge clock);
    #1;
    check("coreResetN", {31'h0, lvl}, {31'h0, coreResetN});
  endtask : wait_core

  // Each accepted read is compared with the oldest expected value.
  always @(posedge clock)
  begin
    if (read === 1'b1 && waitrequest === 1'b0)
    begin
      if (expQ.size() == 0)
      begin
        failures++;
        $display("Error readdata expected none seen %h", readdata);
      end
      else
        check("readdata", expQ.pop_front(), readdata);
    end
  end

  initial
  begin
    #50000;
    failures++;
    report_and_stop();
  end

  initial
  begin
    int i;
    resetn = 1'b0;
    droopReq = 1'b0;
    pinReq = 1'b0;
    dbgReq = 1'b0;
    clockEn = 1'b1;
    read = 1'b0;
    write = 1'b0;
    address = 6'h00;
    writedata = 32'h0;
    failures = 0;
    comparisons = 0;
    seed = 39;
    repeat (8) @(posedge clock);
    resetn <= 1'b1;
    wait_core(1'b1);
    check("bootAddr", 32'h0, fetchAddr);
    rd(rst_wdog_pkg::OFS_CAUSE, 32'h1);
    rd(rst_wdog_pkg::OFS_CTRL, 32'h0);
    repeat (40) @(posedge clock);
    rd(rst_wdog_pkg::OFS_COUNT, 32'h0);
    wr(6'h3c, $random(seed));
    rd(6'h3c, 32'h0);
    wr(rst_wdog_pkg::OFS_WARN, 32'h4);
    wr(rst_wdog_pkg::OFS_MASK, 32'h1);
    wr(rst_wdog_pkg::OFS_CTRL, 32'h1);
    for (i = 0; i < 300 && nmi !== 1'b1; i++)
      @(posedge clock);
    check("nmi", 32'h1, {31'h0, nmi});
    check("irq", 32'h1, {31'h0, irq});
    wr(rst_wdog_pkg::OFS_STATUS, 32'h1);
    @(posedge clock);
    #1;
    check("irq", 32'h0, {31'h0, irq});
    @(posedge clock);
    dbgReq <= 1'b1;
    repeat (4) @(posedge clock);
    wr(rst_wdog_pkg::OFS_CLEAR, 32'h1);
    repeat (100) @(posedge clock);
    rd(rst_wdog_pkg::OFS_COUNT, 32'h0);
    wr(rst_wdog_pkg::OFS_LOCK, $random(seed) | 32'h1);
    rd(rst_wdog_pkg::OFS_LOCK, 32'h1);
    wr(rst_wdog_pkg::OFS_CTRL, 32'h0);
    wr(rst_wdog_pkg::OFS_WARN, $random(seed));
    rd(rst_wdog_pkg::OFS_CTRL, 32'h1);
    rd(rst_wdog_pkg::OFS_WARN, 32'h4);
    wr(rst_wdog_pkg::OFS_LOCK, 32'h5a5a);
    rd(rst_wdog_pkg::OFS_LOCK, 32'h0);
    dbgReq <= 1'b0;
    wr(rst_wdog_pkg::OFS_SWRST, 32'h1);
    wait_core(1'b0);
    check("retainResetN", 32'h1, {31'h0, retainResetN});
    check("debugResetN", 32'h1, {31'h0, debugResetN});
    wait_core(1'b1);
    rd(rst_wdog_pkg::OFS_CAUSE, 32'h8);
    rd(rst_wdog_pkg::OFS_CTRL, 32'h1);
    @(posedge clock);
    pinReq <= 1'b1;
    repeat (20) @(posedge clock);
    #1;
    check("coreResetN", 32'h0, {31'h0, coreResetN});
    check("retainResetN", 32'h0, {31'h0, retainResetN});
    check("debugResetN", 32'h1, {31'h0, debugResetN});
    @(posedge clock);
    pinReq <= 1'b0;
    wait_core(1'b1);
    rd(rst_wdog_pkg::OFS_CAUSE, 32'h4);
    rd(rst_wdog_pkg::OFS_CTRL, 32'h0);
    @(posedge clock);
    droopReq <= 1'b1;
    repeat (5) @(posedge clock);
    #1;
    check("debugResetN", 32'h0, {31'h0, debugResetN});
    check("coreResetN", 32'h0, {31'h0, coreResetN});
    @(posedge clock);
    droopReq <= 1'b0;
    clockEn  <= 1'b0;
    repeat (10) @(posedge clock);
    #1;
    check("debugResetN", 32'h0, {31'h0, debugResetN});
    @(posedge clock);
    clockEn <= 1'b1;
    wait_core(1'b1);
    rd(rst_wdog_pkg::OFS_CAUSE, 32'h2);
    check("bootAddr", 32'h0, fetchAddr);
    report_and_stop();
  end
endmodule : test_reset_and_watchdog_control
